// *** include/mdc_pkg.sv ***
// Constants and types for the motion-change-detection configuration bank.
// Assumes one 8-bit register space shared with the rest of the device map.
package mdc_pkg;

  // Register byte addresses
  localparam logic [7:0] MDC_OFF_CFG_A     = 8'h2f;
  localparam logic [7:0] MDC_OFF_CFG_B     = 8'h30;
  localparam logic [7:0] MDC_OFF_OUT_DBCNT = 8'h31;
  localparam logic [7:0] MDC_OFF_IN_DBCNT  = 8'h32;
  localparam logic [7:0] MDC_OFF_LTHR_LO   = 8'h33;
  localparam logic [7:0] MDC_OFF_LTHR_HI   = 8'h34;
  localparam logic [7:0] MDC_OFF_UTHR_LO   = 8'h35;
  localparam logic [7:0] MDC_OFF_UTHR_HI   = 8'h36;
  localparam logic [7:0] MDC_OFF_ST_IDLE   = 8'h37;
  localparam logic [7:0] MDC_OFF_ST_DECIM  = 8'h38;
  localparam logic [7:0] MDC_OFF_SPARE_RW  = 8'h39;
  localparam logic [7:0] MDC_OFF_SPARE_RO  = 8'h3a;
  localparam logic [7:0] MDC_OFF_WRAP_TO   = 8'h00;

  // Number of byte locations held by the bank (0x2f..0x3a)
  localparam int         MDC_NUM_REGS      = 12;
  localparam int         MDC_IDX_W         = 4;

  // Reset values with the boot pin grounded
  localparam logic [7:0] MDC_RST_GND_CFG_A    = 8'h00;
  localparam logic [7:0] MDC_RST_GND_CFG_B    = 8'h00;
  localparam logic [7:0] MDC_RST_GND_LTHR_LO  = 8'h00;
  localparam logic [7:0] MDC_RST_GND_LTHR_HI  = 8'h00;
  localparam logic [7:0] MDC_RST_GND_UTHR_LO  = 8'h00;
  localparam logic [7:0] MDC_RST_ZERO         = 8'h00;
  // Reset values with the boot pin tied high
  localparam logic [7:0] MDC_RST_VDD_CFG_A    = 8'h38;
  localparam logic [7:0] MDC_RST_VDD_CFG_B    = 8'h00;
  localparam logic [7:0] MDC_RST_VDD_LTHR_LO  = 8'hc0;
  localparam logic [7:0] MDC_RST_VDD_LTHR_HI  = 8'h0f;
  localparam logic [7:0] MDC_RST_VDD_UTHR_LO  = 8'h40;

  // Read value of the read-only spare location, arbitrary
  localparam logic [7:0] MDC_SPARE_RO_VAL     = 8'h00;
  // Position of the reference-refresh bit inside control register b
  localparam int         MDC_REF_REFRESH_BIT  = 0;
  // Threshold field layout
  localparam int         MDC_THR_W            = 12;
  localparam int         MDC_THR_HI_W         = 4;

  // Operating state reported by the device core, Gray coded
  typedef enum logic [1:0] {
    MDC_ST_STANDBY   = 2'b00,
    MDC_ST_ACTIVE    = 2'b01,
    MDC_ST_TRIGGERED = 2'b11,
    MDC_ST_HIBERNATE = 2'b10
  } mdc_state_t;

  // One byte access on the serial register port
  typedef struct packed {
    logic       start;   // Load address before this access
    logic       wr;      // Write strobe
    logic       rd;      // Read strobe
    logic [7:0] addr;    // Start address, used with start
    logic [7:0] wdata;   // Write byte
  } mdc_req_t;

  // Configuration seen by the detection and self-test datapaths
  typedef struct packed {
    logic [7:0]           cfg_a;
    logic [7:0]           cfg_b;
    logic [7:0]           out_dbcnt;
    logic [7:0]           in_dbcnt;
    logic [MDC_THR_W-1:0] lower_thr;
    logic [MDC_THR_W-1:0] upper_thr;
    logic [7:0]           st_idle;
    logic [7:0]           st_decim;
  } mdc_cfg_t;

  // Default of one location, by index and boot level
  function automatic logic [7:0] mdc_default(input logic [MDC_IDX_W-1:0] idx,
                                             input logic boot_high);
    logic [7:0] a;
    a = MDC_OFF_CFG_A + {4'h0, idx};
    case (a)
      MDC_OFF_CFG_A:   mdc_default = boot_high ? MDC_RST_VDD_CFG_A   : MDC_RST_GND_CFG_A;
      MDC_OFF_CFG_B:   mdc_default = boot_high ? MDC_RST_VDD_CFG_B   : MDC_RST_GND_CFG_B;
      MDC_OFF_LTHR_LO: mdc_default = boot_high ? MDC_RST_VDD_LTHR_LO : MDC_RST_GND_LTHR_LO;
      MDC_OFF_LTHR_HI: mdc_default = boot_high ? MDC_RST_VDD_LTHR_HI : MDC_RST_GND_LTHR_HI;
      MDC_OFF_UTHR_LO: mdc_default = boot_high ? MDC_RST_VDD_UTHR_LO : MDC_RST_GND_UTHR_LO;
      default:         mdc_default = MDC_RST_ZERO;
    endcase
  endfunction

endpackage

// *** rtl/mdc_sample_fmt.sv ***
// Byte formatter for one 12-bit output sample.
// Assumes the sample and the order select are stable on the core clock.
`timescale 1ns/10ps
module mdc_sample_fmt (
  // Sample and order
  input  wire logic [11:0] sample_in,
  input  wire logic        byte_order_select_in,
  // Bytes at the lower and the higher address
  output logic      [7:0]  byte0_out,
  output logic      [7:0]  byte1_out
);

  // Low select: little-endian right justified, sign in the upper nibble
  // High select: big-endian left justified, zero fill at the bottom
  always_comb begin
    if (byte_order_select_in) begin
      byte0_out = sample_in[11:4];
      byte1_out = {sample_in[3:0], 4'h0};
    end else begin
      byte0_out = sample_in[7:0];
      byte1_out = {{4{sample_in[11]}}, sample_in[11:8]};
    end
  end

endmodule

// *** rtl/mdc_motion_detect_config_bank.sv ***
// Motion-change-detection and self-test configuration bank, 0x2f..0x3a.
// Assumes the core reports its operating state on this clock and that the
// serial front end delivers one byte strobe per access.
// Operation
// - Standby entry from active keeps contents.
// - Hibernate exit or power reset reloads defaults.
// - Standby-to-run transition clears status registers.
// - Output bytes follow selectable byte order.
// - Standby-to-run transition marks buffer data invalid.
// - Configuration writes accepted only in standby.
// - Run, reset, flush bits writable anywhere.
// - Run-enable frozen in triggered state.
// - Only reference-refresh may be set when active.
// - Control a: latch, axis enables, boot defaults.
// - Control b: enable, reference, mode, debounce.
// - Outside-limits debounce count, reset zero.
// - Inside-limits debounce count, reset zero.
// - Lower threshold split low/high, boot defaults.
// - Upper threshold split low/high, boot defaults.
// - Self-test idle duration register, reset zero.
// - Self-test decimation register, reset zero.
`timescale 1ns/10ps
module mdc_motion_detect_config_bank (
  // Clock, reset and enable
  input  wire logic                 mclk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 ce_in,
  // Serial register port
  input  wire mdc_pkg::mdc_req_t    reg_req_in,
  output logic      [7:0]           reg_rdata_out,
  output logic                      reg_rvalid_out,
  // Core state and boot strap pin
  input  wire mdc_pkg::mdc_state_t  op_state_in,
  input  wire logic                 boot_select_pin_in,
  // Always-writable control bits
  input  wire logic                 run_enable_req_in,
  input  wire logic                 run_enable_val_in,
  input  wire logic                 soft_reset_req_in,
  input  wire logic                 buffer_flush_req_in,
  // Output sample formatting
  input  wire logic                 byte_order_select_in,
  input  wire logic [11:0]          sample_in,
  // Configuration and control outputs
  output mdc_pkg::mdc_cfg_t         cfg_out,
  output logic                      run_enable_out,
  output logic                      soft_reset_out,
  output logic                      buffer_flush_out,
  output logic                      status_clear_out,
  output logic                      buffer_invalidate_out,
  output logic                      boot_mode_out,
  output logic      [7:0]           sample_byte0_out,
  output logic      [7:0]           sample_byte1_out
);

  localparam int IW = mdc_pkg::MDC_IDX_W;
  localparam int NR = mdc_pkg::MDC_NUM_REGS;

  // Index of each location inside the array except the read-write spare
  localparam logic [IW-1:0] IX_CFG_A    = IW'(mdc_pkg::MDC_OFF_CFG_A    - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_CFG_B    = IW'(mdc_pkg::MDC_OFF_CFG_B    - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_OUT      = IW'(mdc_pkg::MDC_OFF_OUT_DBCNT - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_IN       = IW'(mdc_pkg::MDC_OFF_IN_DBCNT  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_LTHR_LO  = IW'(mdc_pkg::MDC_OFF_LTHR_LO  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_LTHR_HI  = IW'(mdc_pkg::MDC_OFF_LTHR_HI  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_UTHR_LO  = IW'(mdc_pkg::MDC_OFF_UTHR_LO  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_UTHR_HI  = IW'(mdc_pkg::MDC_OFF_UTHR_HI  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_ST_IDLE  = IW'(mdc_pkg::MDC_OFF_ST_IDLE  - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_ST_DECIM = IW'(mdc_pkg::MDC_OFF_ST_DECIM - mdc_pkg::MDC_OFF_CFG_A);
  localparam logic [IW-1:0] IX_SPARE_RO = IW'(mdc_pkg::MDC_OFF_SPARE_RO - mdc_pkg::MDC_OFF_CFG_A);

  // Boot strap synchroniser and captured level
  logic                 boot_s1_r;        // First stage, read only by the second
  logic                 boot_s2_r;        // Second stage
  logic                 boot_s3_r;        // Third stage
  logic                 boot_known_r;     // Strap level has been captured
  logic                 boot_known_nxt;
  logic                 boot_level_r;     // Captured strap level
  logic                 boot_level_nxt;
  logic                 boot_load;        // One-cycle default load after release

  // Operating state history
  mdc_pkg::mdc_state_t  prev_state_r;     // State seen on the last enabled edge
  logic                 hib_exit;         // Leaving hibernate this cycle
  logic                 run_entry;        // Standby into active or triggered

  // Register array and access pointer
  logic [7:0]           regs_r   [NR];    // Bank contents
  logic [7:0]           regs_nxt [NR];
  logic [7:0]           ptr_r;            // Burst address pointer
  logic [7:0]           ptr_nxt;
  logic [7:0]           acc_addr;         // Address of the current access
  logic                 acc_hit;          // Access falls inside this bank
  logic [IW-1:0]        acc_idx;          // Array index of the access
  logic                 load_defaults;    // Reload all locations

  // Read and control outputs
  logic [7:0]           rdata_nxt;
  logic                 rvalid_nxt;
  logic                 run_en_nxt;
  logic                 soft_rst_nxt;
  logic                 flush_nxt;
  logic                 stat_clr_nxt;
  logic                 buf_inv_nxt;
  logic [7:0]           fmt_b0;           // Formatter byte at lower address
  logic [7:0]           fmt_b1;           // Formatter byte at higher address

  // Strap capture: one level only, taken once the second and third stages agree.
  // It is held afterwards so that hibernate exit reloads the same defaults.
  always_comb begin
    boot_known_nxt = boot_known_r;
    boot_level_nxt = boot_level_r;
    boot_load      = 1'b0;
    if (!boot_known_r && (boot_s2_r == boot_s3_r)) begin
      boot_known_nxt = 1'b1;
      boot_level_nxt = boot_s3_r;
      boot_load      = 1'b1;
    end
  end

  // Strap registers; reset takes constants, the pin is only sampled later
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boot_s1_r    <= 1'b0;
      boot_s2_r    <= 1'b1;
      boot_s3_r    <= 1'b0;
      boot_known_r <= 1'b0;
      boot_level_r <= 1'b0;
    end else if (ce_in) begin
      boot_s1_r    <= boot_select_pin_in;
      boot_s2_r    <= boot_s1_r;
      boot_s3_r    <= boot_s2_r;
      boot_known_r <= boot_known_nxt;
      boot_level_r <= boot_level_nxt;
    end
  end

  // State transitions; active to standby is deliberately not an event
  always_comb begin
    hib_exit  = (prev_state_r == mdc_pkg::MDC_ST_HIBERNATE) &&
                (op_state_in != mdc_pkg::MDC_ST_HIBERNATE);
    run_entry = (prev_state_r == mdc_pkg::MDC_ST_STANDBY) &&
                ((op_state_in == mdc_pkg::MDC_ST_ACTIVE) ||
                 (op_state_in == mdc_pkg::MDC_ST_TRIGGERED));
  end

  // Software reset reloads the bank too, the same as a power reset
  assign load_defaults = boot_load | hib_exit | soft_reset_req_in;

  // Access address: a start strobe overrides the running pointer
  always_comb begin
    acc_addr = reg_req_in.start ? reg_req_in.addr : ptr_r;
    acc_hit  = (acc_addr >= mdc_pkg::MDC_OFF_CFG_A) && (acc_addr <= mdc_pkg::MDC_OFF_SPARE_RO);
    acc_idx  = IW'(acc_addr - mdc_pkg::MDC_OFF_CFG_A);
  end

  // Pointer moves one byte per access and wraps after the last spare
  always_comb begin
    ptr_nxt = acc_addr;
    if (reg_req_in.wr || reg_req_in.rd) begin
      if (acc_addr == mdc_pkg::MDC_OFF_SPARE_RO) begin
        ptr_nxt = mdc_pkg::MDC_OFF_WRAP_TO;
      end else begin
        ptr_nxt = acc_addr + 8'h01;
      end
    end
  end

  // Next contents: defaults first, then gated writes.
  // Writes outside standby, except setting the refresh bit in active, are dropped silently; the host sees no error.
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (load_defaults) begin
      for (int i = 0; i < NR; i++) begin
        regs_nxt[i] = mdc_pkg::mdc_default(IW'(i), boot_level_nxt);
      end
    end else if (reg_req_in.wr && acc_hit && (acc_idx != IX_SPARE_RO)) begin
      unique case (op_state_in)
        mdc_pkg::MDC_ST_STANDBY: begin
          regs_nxt[acc_idx] = reg_req_in.wdata;
        end
        mdc_pkg::MDC_ST_ACTIVE: begin
          if (acc_idx == IX_CFG_B) begin
            regs_nxt[IX_CFG_B][mdc_pkg::MDC_REF_REFRESH_BIT] =
              regs_r[IX_CFG_B][mdc_pkg::MDC_REF_REFRESH_BIT] |
              reg_req_in.wdata[mdc_pkg::MDC_REF_REFRESH_BIT];
          end
        end
        mdc_pkg::MDC_ST_TRIGGERED: begin
          regs_nxt[acc_idx] = regs_r[acc_idx];
        end
        mdc_pkg::MDC_ST_HIBERNATE: begin
          regs_nxt[acc_idx] = regs_r[acc_idx];
        end
      endcase
    end
  end

  // Read data; unmapped locations of this bank read as zero
  always_comb begin
    rdata_nxt  = reg_rdata_out;
    rvalid_nxt = reg_req_in.rd;
    if (reg_req_in.rd) begin
      if (!acc_hit) begin
        rdata_nxt = 8'h00;
      end else if (acc_idx == IX_SPARE_RO) begin
        rdata_nxt = mdc_pkg::MDC_SPARE_RO_VAL;
      end else begin
        rdata_nxt = regs_r[acc_idx];
      end
    end
  end

  // Always-writable controls; run enable is pinned in the triggered state
  always_comb begin
    run_en_nxt   = run_enable_out;
    soft_rst_nxt = soft_reset_req_in;
    flush_nxt    = buffer_flush_req_in;
    stat_clr_nxt = run_entry;
    buf_inv_nxt  = run_entry;
    if (run_enable_req_in && (op_state_in != mdc_pkg::MDC_ST_TRIGGERED)) begin
      run_en_nxt = run_enable_val_in;
    end
    if (soft_reset_req_in || hib_exit) begin
      run_en_nxt = 1'b0;
    end
  end

  // Bank contents; reset holds the grounded-pin values until the strap is known
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NR; i++) begin
        regs_r[i] <= mdc_pkg::MDC_RST_ZERO;
      end
    end else if (ce_in) begin
      for (int i = 0; i < NR; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Pointer, state history and output flops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_r                 <= mdc_pkg::MDC_OFF_WRAP_TO;
      prev_state_r          <= mdc_pkg::MDC_ST_STANDBY;
      reg_rdata_out         <= 8'h00;
      reg_rvalid_out        <= 1'b0;
      run_enable_out        <= 1'b0;
      soft_reset_out        <= 1'b0;
      buffer_flush_out      <= 1'b0;
      status_clear_out      <= 1'b0;
      buffer_invalidate_out <= 1'b0;
      sample_byte0_out      <= 8'h00;
      sample_byte1_out      <= 8'h00;
    end else if (ce_in) begin
      ptr_r                 <= ptr_nxt;
      prev_state_r          <= op_state_in;
      reg_rdata_out         <= rdata_nxt;
      reg_rvalid_out        <= rvalid_nxt;
      run_enable_out        <= run_en_nxt;
      soft_reset_out        <= soft_rst_nxt;
      buffer_flush_out      <= flush_nxt;
      status_clear_out      <= stat_clr_nxt;
      buffer_invalidate_out <= buf_inv_nxt;
      sample_byte0_out      <= fmt_b0;
      sample_byte1_out      <= fmt_b1;
    end
  end

  // Datapath view of the bank; fields come straight from the flops
  assign cfg_out.cfg_a     = regs_r[IX_CFG_A];
  assign cfg_out.cfg_b     = regs_r[IX_CFG_B];
  assign cfg_out.out_dbcnt = regs_r[IX_OUT];
  assign cfg_out.in_dbcnt  = regs_r[IX_IN];
  assign cfg_out.lower_thr = {regs_r[IX_LTHR_HI][mdc_pkg::MDC_THR_HI_W-1:0],
                              regs_r[IX_LTHR_LO]};
  assign cfg_out.upper_thr = {regs_r[IX_UTHR_HI][mdc_pkg::MDC_THR_HI_W-1:0],
                              regs_r[IX_UTHR_LO]};
  assign cfg_out.st_idle   = regs_r[IX_ST_IDLE];
  assign cfg_out.st_decim  = regs_r[IX_ST_DECIM];
  assign boot_mode_out     = boot_level_r;

  // Output sample byte order
  mdc_sample_fmt u_fmt (
    .sample_in            (sample_in),
    .byte_order_select_in (byte_order_select_in),
    .byte0_out            (fmt_b0),
    .byte1_out            (fmt_b1)
  );

endmodule

// *** sim/mdc_bank_asserts.sv ***
// Concurrent checks on the ports of the configuration bank.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module mdc_bank_asserts (
  // Clock, reset and enable
  input wire logic                mclk_in,
  input wire logic                resetn_in,
  input wire logic                ce_in,
  // Register port and core state
  input wire mdc_pkg::mdc_req_t   reg_req_in,
  input wire logic                reg_rvalid_out,
  input wire mdc_pkg::mdc_state_t op_state_in,
  // Control requests and sample input
  input wire logic                run_enable_req_in,
  input wire logic                run_enable_val_in,
  input wire logic                soft_reset_req_in,
  input wire logic                buffer_flush_req_in,
  input wire logic                byte_order_select_in,
  input wire logic [11:0]         sample_in,
  // Bank outputs
  input wire mdc_pkg::mdc_cfg_t   cfg_out,
  input wire logic                run_enable_out,
  input wire logic                soft_reset_out,
  input wire logic                buffer_flush_out,
  input wire logic                status_clear_out,
  input wire logic                buffer_invalidate_out,
  input wire logic [7:0]          sample_byte0_out,
  input wire logic [7:0]          sample_byte1_out
);
  // Short state names keep the properties readable
  localparam mdc_pkg::mdc_state_t SB = mdc_pkg::MDC_ST_STANDBY;
  localparam mdc_pkg::mdc_state_t AC = mdc_pkg::MDC_ST_ACTIVE;
  localparam mdc_pkg::mdc_state_t TR = mdc_pkg::MDC_ST_TRIGGERED;
  localparam mdc_pkg::mdc_state_t HB = mdc_pkg::MDC_ST_HIBERNATE;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Hibernate exit and soft reset reload defaults, so they are excluded
  chk_trig_cfg_frozen: assert property (
    op_state_in == TR && $past(op_state_in) != HB && !soft_reset_req_in |=> $stable(cfg_out))
    else $error("configuration changed in triggered state");
  chk_active_ref_only: assert property (
    op_state_in == AC && $past(op_state_in) != HB && !soft_reset_req_in |=>
    cfg_out.cfg_a == $past(cfg_out.cfg_a) && cfg_out.cfg_b[7:1] == $past(cfg_out.cfg_b[7:1])
    && (cfg_out.cfg_b[mdc_pkg::MDC_REF_REFRESH_BIT] || !$past(cfg_out.cfg_b[0])))
    else $error("configuration changed beyond refresh bit in active state");
  chk_standby_keeps: assert property (
    $past(op_state_in) == AC && op_state_in == SB && !reg_req_in.wr && !soft_reset_req_in
    |=> $stable(cfg_out)) else $error("contents lost entering standby");
  chk_run_clear_pulse: assert property (
    ce_in && $past(op_state_in) == SB && (op_state_in == AC || op_state_in == TR)
    |=> status_clear_out && buffer_invalidate_out) else $error("no clear pulse on run entry");
  chk_clear_has_cause: assert property (
    status_clear_out || buffer_invalidate_out |-> $past(op_state_in, 2) == SB
    && ($past(op_state_in) == AC || $past(op_state_in) == TR))
    else $error("clear pulse without run entry");
  chk_run_trig_frozen: assert property (
    op_state_in == TR && $past(op_state_in) != HB && !soft_reset_req_in
    |=> $stable(run_enable_out)) else $error("run enable moved in triggered state");
  chk_run_write: assert property (
    ce_in && run_enable_req_in && (op_state_in == SB || op_state_in == AC) && !soft_reset_req_in
    && $past(op_state_in) != HB |=> run_enable_out == $past(run_enable_val_in))
    else $error("run enable write not taken");
  chk_ctl_pulses: assert property (
    ce_in && (soft_reset_req_in || buffer_flush_req_in) |=> soft_reset_out ==
    $past(soft_reset_req_in) && buffer_flush_out == $past(buffer_flush_req_in))
    else $error("reset or flush pulse missing");
  chk_sample_order: assert property (
    ce_in |=> {sample_byte1_out, sample_byte0_out} == ($past(byte_order_select_in) ?
    {$past(sample_in[3:0]), 4'h0, $past(sample_in[11:4])} :
    {{4{$past(sample_in[11])}}, $past(sample_in)})) else $error("sample bytes wrong");
  // Main scenarios reached
  cov_run_entry: cover property (status_clear_out);
  cov_burst_read: cover property (reg_rvalid_out ##1 reg_rvalid_out);
  cov_flush: cover property (buffer_flush_out);
endmodule
bind mdc_motion_detect_config_bank mdc_bank_asserts u_chk (
  .mclk_in, .resetn_in, .ce_in, .reg_req_in, .reg_rvalid_out, .op_state_in,
  .run_enable_req_in, .run_enable_val_in, .soft_reset_req_in, .buffer_flush_req_in,
  .byte_order_select_in, .sample_in, .cfg_out, .run_enable_out, .soft_reset_out,
  .buffer_flush_out, .status_clear_out, .buffer_invalidate_out, .sample_byte0_out,
  .sample_byte1_out);

// *** sim/mdc_host_model.sv ***
// Host processor model driving the byte strobe register port.
// Assumes the bench calls its tasks from one process; drives on falling edges.
`timescale 1ns/10ps
module mdc_host_model (
  // Core clock
  input  wire logic        mclk_in,
  // Request towards the bank
  output mdc_pkg::mdc_req_t req_out
);
  initial req_out = '0;
  // One byte access; a is the target, sent only with start
  task automatic put(input logic st, input logic wr, input logic rd,
                     input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    // Factory spare only ever receives its reset value
    req_out = {st, wr, rd, st ? a : ~a, (a == mdc_pkg::MDC_OFF_SPARE_RW) ? 8'h00 : d};
  endtask
  // Release strobes; stale bytes are inverted so they never look valid
  task automatic idle();
    @(negedge mclk_in);
    req_out = {3'b000, ~req_out.addr, ~req_out.wdata};
  endtask
endmodule

// *** sim/mdc_motion_detect_config_bank_tb.sv ***
// Self-checking bench for the configuration bank.
// Assumes the host model file and the bound checker; inputs move on falling edges.
`timescale 1ns/10ps
module mdc_motion_detect_config_bank_tb;
  localparam int CW = $bits(mdc_pkg::mdc_cfg_t);
  // Stimulus
  logic                mclk_in   = 1'b0;
  logic                resetn_in = 1'b0;
  logic                ce        = 1'b1;
  logic                boot_pin  = 1'b0;
  mdc_pkg::mdc_state_t st        = mdc_pkg::MDC_ST_STANDBY;
  logic                run_req   = 1'b0;
  logic                run_val   = 1'b0;
  logic                srst_req  = 1'b0;
  logic                flush_req = 1'b0;
  logic                order_sel = 1'b0;
  logic [11:0]         sample    = 12'h000;
  // Host request and bank outputs
  mdc_pkg::mdc_req_t   req;
  mdc_pkg::mdc_cfg_t   cfg;
  logic [7:0]          rdata, b0, b1;
  logic                rvalid, run_en, srst_out, flush_out, clr_out, inval_out, boot_out;
  // Expected register image and counters
  logic [7:0]          mdl [12];
  int                  mismatches = 0;
  int                  num_checks = 0;
  initial forever #12.5 mclk_in = ~mclk_in;
  mdc_host_model u_host (.mclk_in(mclk_in), .req_out(req));
  mdc_motion_detect_config_bank DUT (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .op_state_in(st),
    .boot_select_pin_in(boot_pin), .run_enable_req_in(run_req), .run_enable_val_in(run_val),
    .soft_reset_req_in(srst_req), .buffer_flush_req_in(flush_req),
    .byte_order_select_in(order_sel), .sample_in(sample), .cfg_out(cfg),
    .run_enable_out(run_en), .soft_reset_out(srst_out), .buffer_flush_out(flush_out),
    .status_clear_out(clr_out), .buffer_invalidate_out(inval_out), .boot_mode_out(boot_out),
    .sample_byte0_out(b0), .sample_byte1_out(b1));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Thresholds join the low nibble of the high byte to the low byte
  function automatic mdc_pkg::mdc_cfg_t img_cfg();
    img_cfg = {mdl[0], mdl[1], mdl[2], mdl[3], mdl[5][3:0], mdl[4],
               mdl[7][3:0], mdl[6], mdl[8], mdl[9]};
  endfunction
  // Strap-high defaults differ at four locations
  task automatic load_dflt(input logic hi);
    mdl = '{default: 8'h00};
    if (hi) {mdl[0], mdl[4], mdl[5], mdl[6]} = 32'h38c00f40;
  endtask
  task automatic set_state(input mdc_pkg::mdc_state_t s);
    @(negedge mclk_in);
    st = s;
  endtask
  task automatic pulse_ctl(input logic run, input logic val, input logic sr, input logic fl);
    @(negedge mclk_in);
    {run_req, run_val, srst_req, flush_req} = {run, val, sr, fl};
    @(negedge mclk_in);
    {run_req, run_val, srst_req, flush_req} = 4'h0;
  endtask
  // Image via cfg_out, then a burst read wrapping past 0x3a
  task automatic check_image();
    chk(cfg, img_cfg());
    for (int i = 0; i <= 13; i++) begin
      if (i < 13) u_host.put(i == 0, 1'b0, 1'b1, 8'(8'h2f + i), 8'h00);
      else u_host.idle();
      if (i > 0 && i < 12) chk(CW'(rdata), CW'(mdl[i-1]));
      if (i == 12) chk(CW'(rdata), CW'(mdc_pkg::MDC_SPARE_RO_VAL));
      if (i == 13) chk(CW'({rvalid, rdata}), CW'(9'h100));
    end
  endtask
  task automatic test_defaults(input logic hi);
    resetn_in = 1'b0;
    boot_pin = hi;
    repeat (3) @(negedge mclk_in);
    resetn_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    load_dflt(hi);
    chk(CW'(boot_out), CW'(hi));
    check_image();
  endtask
  // Standby burst over every location, read-only spare included
  task automatic test_standby_burst();
    for (int i = 0; i < 12; i++) begin
      u_host.put(i == 0, 1'b1, 1'b0, 8'(8'h2f + i), 8'(i * 16 + 6));
      if (i < 10) mdl[i] = 8'(i * 16 + 6);
    end
    u_host.idle();
    mdl[10] = 8'h00;
    check_image();
  endtask
  task automatic test_active();
    set_state(mdc_pkg::MDC_ST_ACTIVE);
    u_host.put(1'b1, 1'b1, 1'b0, mdc_pkg::MDC_OFF_CFG_A, 8'hff);
    chk(CW'({clr_out, inval_out}), CW'(2'b11));
    u_host.put(1'b0, 1'b1, 1'b0, mdc_pkg::MDC_OFF_CFG_B, 8'hff);
    u_host.idle();
    mdl[1] = mdl[1] | 8'h01;
    pulse_ctl(1'b1, 1'b1, 1'b0, 1'b0);
    chk(CW'(run_en), CW'(1'b1));
    set_state(mdc_pkg::MDC_ST_STANDBY);
    check_image();
  endtask
  task automatic test_triggered();
    set_state(mdc_pkg::MDC_ST_TRIGGERED);
    u_host.put(1'b1, 1'b1, 1'b0, mdc_pkg::MDC_OFF_OUT_DBCNT, 8'h99);
    chk(CW'({clr_out, inval_out}), CW'(2'b11));
    u_host.idle();
    pulse_ctl(1'b1, 1'b0, 1'b0, 1'b1);
    chk(CW'({run_en, flush_out}), CW'(2'b11));
    set_state(mdc_pkg::MDC_ST_STANDBY);
    check_image();
  endtask
  task automatic test_soft_reset();
    pulse_ctl(1'b0, 1'b0, 1'b1, 1'b0);
    chk(CW'({srst_out, run_en}), CW'(2'b10));
    load_dflt(1'b1);
    check_image();
  endtask
  task automatic test_hibernate();
    pulse_ctl(1'b1, 1'b1, 1'b0, 1'b0);
    u_host.put(1'b1, 1'b1, 1'b0, mdc_pkg::MDC_OFF_OUT_DBCNT, 8'h77);
    u_host.idle();
    set_state(mdc_pkg::MDC_ST_HIBERNATE);
    set_state(mdc_pkg::MDC_ST_STANDBY);
    @(negedge mclk_in);
    chk(CW'(run_en), CW'(1'b0));
    check_image();
  endtask
  task automatic test_sample();
    @(negedge mclk_in);
    sample = 12'h9a5;
    @(negedge mclk_in);
    chk(CW'({b1, b0}), CW'(16'hf9a5));
    order_sel = 1'b1;
    @(negedge mclk_in);
    chk(CW'({b1, b0}), CW'(16'h509a));
    // Enable low must hold the bytes
    {ce, sample} = 13'h0000;
    @(negedge mclk_in);
    chk(CW'({b1, b0}), CW'(16'h509a));
  endtask
  initial begin
    test_defaults(1'b0);
    test_defaults(1'b1);
    test_standby_burst();
    test_active();
    test_triggered();
    test_soft_reset();
    test_hibernate();
    test_sample();
    finish_test();
  end
  // Guard against a hang
  initial begin
    #(100000 * 25);
    mismatches++;
    finish_test();
  end
endmodule
